// >>> atc_pkg.sv
// Shared constants, register map and carrier types for the accumulating timer/counter bank
package atc_pkg;
    ////////////////////////////////////////////////////////////////////////////////
    // Timing: 50 MHz system clock, 10 ms base tick, tenth tick from ten base ticks
    localparam int CLK_PERIOD_NS = 20;
    localparam int FAST_TICK_NS = 10_000_000;
    localparam int FAST_TICK_CYC = (FAST_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] FAST_PER_SLOW = 4'hA;
    ////////////////////////////////////////////////////////////////////////////////
    // Bus geometry: byte address is four times the word index
    localparam int ADDR_W = 16;
    localparam int IDX_W = 14;
    ////////////////////////////////////////////////////////////////////////////////
    // Slot numbers and memory word indices of current values
    localparam int CNT_BASE = 1000;
    localparam int TA_SLOT = 0;
    localparam int TF_SLOT = 2;
    localparam int UC_SLOT = 0;
    localparam int UD_SLOT = 1;
    localparam int SG_SLOT = 3;
    localparam logic [IDX_W-1:0] W_TA_LO = 14'(TA_SLOT);
    localparam logic [IDX_W-1:0] W_TA_HI = 14'(TA_SLOT + 1);
    localparam logic [IDX_W-1:0] W_TF_LO = 14'(TF_SLOT);
    localparam logic [IDX_W-1:0] W_TF_HI = 14'(TF_SLOT + 1);
    localparam logic [IDX_W-1:0] W_UC = 14'(CNT_BASE + UC_SLOT);
    localparam logic [IDX_W-1:0] W_UD_LO = 14'(CNT_BASE + UD_SLOT);
    localparam logic [IDX_W-1:0] W_UD_HI = 14'(CNT_BASE + UD_SLOT + 1);
    localparam logic [IDX_W-1:0] W_SG = 14'(CNT_BASE + SG_SLOT);
    ////////////////////////////////////////////////////////////////////////////////
    // Control, command, status and preset registers (word indices)
    localparam logic [IDX_W-1:0] IDX_CTRL = 14'h0800;
    localparam logic [IDX_W-1:0] IDX_CMD = 14'h0801;
    localparam logic [IDX_W-1:0] IDX_STATUS = 14'h0802;
    localparam logic [IDX_W-1:0] IDX_TA_PRE = 14'h0804;
    localparam logic [IDX_W-1:0] IDX_TF_PRE = 14'h0805;
    localparam logic [IDX_W-1:0] IDX_UC_PRE = 14'h0806;
    localparam logic [IDX_W-1:0] IDX_UD_PRE = 14'h0807;
    localparam logic [IDX_W-1:0] IDX_SG_PRE = 14'h0808;
    localparam int CMD_SG_CLR_BIT = 0;
    ////////////////////////////////////////////////////////////////////////////////
    // Saturation limits (BCD) and reset values
    localparam logic [31:0] TA_MAX = 32'h99999999;
    localparam logic [31:0] TF_MAX = 32'h09999999;
    localparam logic [31:0] UD_MAX = 32'h99999999;
    localparam logic [15:0] WORD_MAX = 16'h9999;
    localparam logic [31:0] PRE_RST = 32'h00000000;
    ////////////////////////////////////////////////////////////////////////////////
    // Input bits written by the ladder program
    typedef struct packed {
        logic [21:0] rsvd;
        logic sgIn;
        logic udRst;
        logic udDn;
        logic udUp;
        logic ucRst;
        logic ucIn;
        logic tfRst;
        logic tfEn;
        logic taRst;
        logic taEn;
    } atc_ctrl_t;
    // Done bits of the five units
    typedef struct packed {
        logic sg;
        logic ud;
        logic uc;
        logic tf;
        logic ta;
    } atc_done_t;
endpackage

// >>> atc_timer_counters.sv
// Accumulating timers and event counters with an APB register window
// Operation
// R1 - Standard timer steps 0.1 s, max 9999999.9
// R2 - Fast timer steps 0.01 s, max 99999.99
// R3 - Timer preset and value are 8-digit BCD
// R4 - Timer counts only while enabled, else holds
// R5 - Timer reset clears and holds at zero
// R6 - Timer done when value reaches preset
// R7 - Timer uses two consecutive slots
// R8 - Timer n value readable at word n
// R9 - Up counter increments on rising input
// R10 - Up counter reset forces zero
// R11 - Up counter saturates at 9999
// R12 - Up counter words are 16-bit BCD
// R13 - Counter n value at word n+1000
// R14 - Counter done when count reaches preset
// R15 - Up/down counter: up, down, reset inputs
// R16 - Up/down counter uses two consecutive slots
// R17 - Stage counter cleared only by command
// R18 - Stage counter continues to 9999, holds
// R19 - Program keeps unused count input off
// R20 - Prescaled ticks, decimal digit carry arithmetic
// R21 - Edges found against previous sample
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module atc_timer_counters
    import atc_pkg::*;
#(
    parameter int FAST_TICK_CYCLES = atc_pkg::FAST_TICK_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [atc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Done bits for the ladder program
    output atc_pkg::atc_done_t doneBits
);
    import atc_pkg::*;

    localparam int PW = $clog2(FAST_TICK_CYCLES + 1);

    ////////////////////////////////////////////////////////////////////////////////
    // BCD helpers
    // Increment with decimal carry from digit to digit
    function automatic logic [31:0] bcdInc(input logic [31:0] v);
        logic [31:0] r;
        logic c;
        r = v;
        c = 1'b1;
        for (int i = 0; i < 8; i++) begin
            if (c) begin
                if (r[4*i +: 4] == 4'h9) begin
                    r[4*i +: 4] = 4'h0;
                end else begin
                    r[4*i +: 4] = r[4*i +: 4] + 4'h1;
                    c = 1'b0;
                end
            end
        end
        return r;
    endfunction

    // Decrement with decimal borrow; callers never pass zero
    function automatic logic [31:0] bcdDec(input logic [31:0] v);
        logic [31:0] r;
        logic b;
        r = v;
        b = 1'b1;
        for (int i = 0; i < 8; i++) begin
            if (b) begin
                if (r[4*i +: 4] == 4'h0) begin
                    r[4*i +: 4] = 4'h9;
                end else begin
                    r[4*i +: 4] = r[4*i +: 4] - 4'h1;
                    b = 1'b0;
                end
            end
        end
        return r;
    endfunction

    // Byte-lane merge for APB writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // State
    logic [PW-1:0] fastCnt_q; // Base tick prescaler
    logic [3:0] slowCnt_q; // Tenth tick divider
    logic fastTick_q; // One-cycle 10 ms enable
    logic slowTick_q; // One-cycle 100 ms enable
    atc_ctrl_t ctrl_q; // Ladder inputs
    atc_ctrl_t prev_q; // Inputs of the previous update cycle
    logic [31:0] taVal_q, tfVal_q, udVal_q; // Double-word BCD current values
    logic [15:0] ucVal_q, sgVal_q; // Single-word BCD current values
    logic [31:0] taPre_q, tfPre_q, udPre_q; // Double-word presets
    logic [15:0] ucPre_q, sgPre_q; // Single-word presets
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    atc_done_t done_q;

    // Bus decode signals
    logic [IDX_W-1:0] idx;
    logic access;
    logic wrEn;
    logic sgClr;
    logic [31:0] rdData;
    logic rdHit;
    logic wrOk;
    logic ucEdge, udUpEdge, udDnEdge, sgEdge;

    assign idx = paddr[ADDR_W-1:2];
    assign access = psel && penable && !pready_q;
    assign wrEn = psel && penable && pready_q && pwrite && wrOk;
    assign sgClr = wrEn && (idx == IDX_CMD) && pstrb[0] && pwdata[CMD_SG_CLR_BIT];

    ////////////////////////////////////////////////////////////////////////////////
    // Prescaler: a 10 ms enable and a 100 ms enable from the system clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fastCnt_q <= '0;
            fastTick_q <= 1'b0;
        end else if (fastCnt_q == PW'(FAST_TICK_CYCLES - 1)) begin
            fastCnt_q <= '0;
            fastTick_q <= 1'b1; // [R20]
        end else begin
            fastCnt_q <= fastCnt_q + 1'b1;
            fastTick_q <= 1'b0;
        end
    end

    // Tenth tick follows every tenth base tick one cycle later so both bases stay phase locked
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slowCnt_q <= 4'h0;
            slowTick_q <= 1'b0;
        end else if (fastTick_q && slowCnt_q == FAST_PER_SLOW - 4'h1) begin
            slowCnt_q <= 4'h0;
            slowTick_q <= 1'b1; // [R20]
        end else begin
            slowCnt_q <= fastTick_q ? slowCnt_q + 4'h1 : slowCnt_q;
            slowTick_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Edge detection against the previous sample of each count input
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_q <= '0;
        end else begin
            prev_q <= ctrl_q; // [R21]
        end
    end

    assign ucEdge = ctrl_q.ucIn && !prev_q.ucIn; // [R21]
    assign udUpEdge = ctrl_q.udUp && !prev_q.udUp;
    assign udDnEdge = ctrl_q.udDn && !prev_q.udDn;
    assign sgEdge = ctrl_q.sgIn && !prev_q.sgIn;

    ////////////////////////////////////////////////////////////////////////////////
    // Accumulating timers: reset wins, enable gates the tick, value holds otherwise
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            taVal_q <= '0;
        end else if (ctrl_q.taRst) begin
            taVal_q <= '0; // [R5]
        end else if (ctrl_q.taEn && slowTick_q && taVal_q != TA_MAX) begin
            taVal_q <= bcdInc(taVal_q); // [R1] [R3] [R4] [R20]
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tfVal_q <= '0;
        end else if (ctrl_q.tfRst) begin
            tfVal_q <= '0; // [R5]
        end else if (ctrl_q.tfEn && fastTick_q && tfVal_q != TF_MAX) begin
            tfVal_q <= bcdInc(tfVal_q); // [R2] [R3] [R4] [R20]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Up counter: counts rising edges, saturates, level reset holds it at zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ucVal_q <= '0;
        end else if (ctrl_q.ucRst) begin
            ucVal_q <= '0; // [R10]
        end else if (ucEdge && ucVal_q != WORD_MAX) begin
            ucVal_q <= 16'(bcdInc({16'h0000, ucVal_q})); // [R9] [R11] [R12]
        end
    end

    // Up/down counter: an edge only counts while the opposite input is off
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            udVal_q <= '0;
        end else if (ctrl_q.udRst) begin
            udVal_q <= '0; // [R15]
        end else if (udUpEdge && !ctrl_q.udDn && udVal_q != UD_MAX) begin
            udVal_q <= bcdInc(udVal_q); // [R15] [R19]
        end else if (udDnEdge && !ctrl_q.udUp && udVal_q != '0) begin
            udVal_q <= bcdDec(udVal_q); // [R15] [R19]
        end
    end

    // Stage counter: no reset input; only the clear command zeroes it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sgVal_q <= '0;
        end else if (sgClr) begin
            sgVal_q <= '0; // [R17]
        end else if (sgEdge && sgVal_q != WORD_MAX) begin
            sgVal_q <= 16'(bcdInc({16'h0000, sgVal_q})); // [R17] [R18]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Done bits: valid BCD orders like binary, so a plain compare suffices
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            done_q <= '0;
        end else begin
            done_q.ta <= taVal_q >= taPre_q; // [R6]
            done_q.tf <= tfVal_q >= tfPre_q; // [R6]
            done_q.uc <= ucVal_q >= ucPre_q; // [R14]
            done_q.ud <= udVal_q >= udPre_q; // [R14]
            done_q.sg <= sgVal_q >= sgPre_q; // [R14] [R18]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Writable registers: control inputs and presets
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= '0;
            taPre_q <= PRE_RST;
            tfPre_q <= PRE_RST;
            udPre_q <= PRE_RST;
            ucPre_q <= PRE_RST[15:0];
            sgPre_q <= PRE_RST[15:0];
        end else if (wrEn) begin
            if (idx == IDX_CTRL) begin
                ctrl_q <= atc_ctrl_t'({22'h0, 10'(merge(ctrl_q, pwdata, pstrb))});
            end else if (idx == IDX_TA_PRE) begin
                taPre_q <= merge(taPre_q, pwdata, pstrb); // [R3]
            end else if (idx == IDX_TF_PRE) begin
                tfPre_q <= merge(tfPre_q, pwdata, pstrb); // [R3]
            end else if (idx == IDX_UD_PRE) begin
                udPre_q <= merge(udPre_q, pwdata, pstrb);
            end else if (idx == IDX_UC_PRE) begin
                ucPre_q <= 16'(merge({16'h0000, ucPre_q}, pwdata, pstrb)); // [R12]
            end else if (idx == IDX_SG_PRE) begin
                sgPre_q <= 16'(merge({16'h0000, sgPre_q}, pwdata, pstrb));
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read decode; double-word values put the low four digits in slot n, high in n+1
    always_comb begin
        rdData = '0;
        rdHit = 1'b1;
        wrOk = 1'b0;
        if (idx == W_TA_LO) begin
            rdData = {16'h0000, taVal_q[15:0]}; // [R7] [R8]
        end else if (idx == W_TA_HI) begin
            rdData = {16'h0000, taVal_q[31:16]}; // [R7] [R8]
        end else if (idx == W_TF_LO) begin
            rdData = {16'h0000, tfVal_q[15:0]}; // [R7] [R8]
        end else if (idx == W_TF_HI) begin
            rdData = {16'h0000, tfVal_q[31:16]}; // [R7] [R8]
        end else if (idx == W_UC) begin
            rdData = {16'h0000, ucVal_q}; // [R13]
        end else if (idx == W_UD_LO) begin
            rdData = {16'h0000, udVal_q[15:0]}; // [R13] [R16]
        end else if (idx == W_UD_HI) begin
            rdData = {16'h0000, udVal_q[31:16]}; // [R13] [R16]
        end else if (idx == W_SG) begin
            rdData = {16'h0000, sgVal_q}; // [R13]
        end else if (idx == IDX_CTRL) begin
            rdData = ctrl_q;
            wrOk = 1'b1;
        end else if (idx == IDX_CMD) begin
            wrOk = 1'b1; // Command word reads as zero
        end else if (idx == IDX_STATUS) begin
            rdData = {27'h0, done_q};
        end else if (idx == IDX_TA_PRE) begin
            rdData = taPre_q;
            wrOk = 1'b1;
        end else if (idx == IDX_TF_PRE) begin
            rdData = tfPre_q;
            wrOk = 1'b1;
        end else if (idx == IDX_UC_PRE) begin
            rdData = {16'h0000, ucPre_q};
            wrOk = 1'b1;
        end else if (idx == IDX_UD_PRE) begin
            rdData = udPre_q;
            wrOk = 1'b1;
        end else if (idx == IDX_SG_PRE) begin
            rdData = {16'h0000, sgPre_q};
            wrOk = 1'b1;
        end else begin
            rdHit = 1'b0; // Unmapped word
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // APB answer: one wait state, so pready and data both come from flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= '0;
        end else begin
            pready_q <= access;
            pslverr_q <= access && (!rdHit || (pwrite && !wrOk));
            if (access && !pwrite) begin
                prdata_q <= rdData;
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign doneBits = done_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_taRun;
        ctrl_q.taEn && !ctrl_q.taRst && slowTick_q && taVal_q != TA_MAX;
    endsequence

    sequence s_ucCount;
        ctrl_q.ucIn && !prev_q.ucIn && !ctrl_q.ucRst && ucVal_q != WORD_MAX;
    endsequence

    a_ta_step: assert property (s_taRun |=> taVal_q == bcdInc($past(taVal_q))) // [R1]
        else $error("standard timer did not step by one tenth");
    a_tf_limit: assert property (tfVal_q <= TF_MAX) // [R2]
        else $error("fast timer passed its maximum");
    a_ta_hold: assert property (!ctrl_q.taEn && !ctrl_q.taRst |=> $stable(taVal_q)) // [R4]
        else $error("disabled timer changed value");
    a_ta_reset: assert property (ctrl_q.taRst |=> taVal_q == '0) // [R5]
        else $error("timer not cleared by reset");
    a_ta_done: assert property ($changed(taVal_q) ##1 1'b1 |-> // [R6]
        done_q.ta == ($past(taVal_q) >= $past(taPre_q)))
        else $error("timer done bit disagrees with value");
    a_uc_count: assert property (s_ucCount |=> ucVal_q != $past(ucVal_q) ##1 // [R9]
        !ctrl_q.ucIn || ctrl_q.ucRst || $stable(ucVal_q))
        else $error("up counter missed or repeated an edge");
    a_uc_reset: assert property (ctrl_q.ucRst |=> ucVal_q == '0 ##1 !done_q.uc || ucPre_q == '0) // [R10]
        else $error("up counter reset failed");
    a_uc_sat: assert property (ucVal_q == WORD_MAX && !ctrl_q.ucRst |=> ucVal_q == WORD_MAX) // [R11]
        else $error("up counter wrapped");
    a_ud_gate: assert property (ctrl_q.udUp && ctrl_q.udDn && !ctrl_q.udRst |=> $stable(udVal_q)) // [R15]
        else $error("up/down counted with both inputs on");
    a_sg_keep: assert property (!sgClr && !(ctrl_q.sgIn && !prev_q.sgIn) |=> $stable(sgVal_q)) // [R17]
        else $error("stage counter changed without cause");
    a_tick_spacing: assert property (fastTick_q |=> !fastTick_q [*2]) // [R20]
        else $error("base tick not a single pulse");
endmodule
`default_nettype wire

// >>> atc_ladder_model.sv
// Ladder program model on the register bus
`timescale 1ns/1ps
`default_nettype none
module atc_ladder_model (
    // Clock
    input wire logic clk,
    // APB master side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [atc_pkg::ADDR_W-1:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    import atc_pkg::*;
    ////////////////////////////////////////////////////////////////////////////////
    logic hung; // Transfer timed out

    // Idle bus from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'h0;
        hung = 1'b0;
    end

    // One APB transfer, held until pready
    task automatic xfer(input logic isWr, input logic [IDX_W-1:0] idx, input logic [31:0] wd,
                        input logic [3:0] strb, output logic [31:0] rd, output logic err);
        logic ok;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= isWr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        pstrb <= strb;
        @(posedge clk);
        penable <= 1'b1;
        ok = 1'b0;
        // Bounded wait
        for (int n = 0; n < 16 && !ok; n++) begin
            @(posedge clk);
            ok = (pready === 1'b1);
        end
        rd = prdata;
        err = pslverr;
        hung = hung | ~ok;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Raise count inputs over base, then drop
    task automatic pulse(input atc_ctrl_t base, input atc_ctrl_t bits);
        atc_ctrl_t c;
        logic [31:0] rd;
        logic err;
        c = base | bits;
        // Unused direction held off
        if (bits.udUp) begin
            c.udDn = 1'b0;
        end
        if (bits.udDn) begin
            c.udUp = 1'b0;
        end
        xfer(1'b1, IDX_CTRL, 32'(c), 4'hF, rd, err);
        xfer(1'b1, IDX_CTRL, 32'(base), 4'hF, rd, err);
    endtask
endmodule
`default_nettype wire

// >>> tb_accumulating_timer_counters.sv
// Bench for the timer and counter bank
`timescale 1ns/1ps
`default_nettype none
module tb_accumulating_timer_counters;
    import atc_pkg::*;
    ////////////////////////////////////////////////////////////////////////////////
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    atc_done_t doneBits; // Done levels straight from the block
    int mismatches, checked;

    // Short base tick: fast step 4 cycles, slow 40
    atc_timer_counters #(.FAST_TICK_CYCLES(4)) atc_timer_counters_inst (.clk(clk),
        .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .doneBits(doneBits));
    atc_ladder_model atc_ladder_model_inst (.clk(clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever begin
            #10 clk = ~clk;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Four-state compare
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Hung transfer ends the run
    task automatic guard;
        if (atc_ladder_model_inst.hung) begin
            mismatches++;
            conclude();
        end
    endtask
    task automatic rd(input logic [IDX_W-1:0] idx, output logic [31:0] v, output logic e);
        atc_ladder_model_inst.xfer(1'b0, idx, 32'h0, 4'h0, v, e);
        guard();
    endtask
    task automatic wr(input logic [IDX_W-1:0] idx, input logic [31:0] d, output logic e);
        logic [31:0] v;
        atc_ladder_model_inst.xfer(1'b1, idx, d, 4'hF, v, e);
        guard();
    endtask
    task automatic pulse(input atc_ctrl_t base, input atc_ctrl_t bits);
        atc_ladder_model_inst.pulse(base, bits);
        guard();
    endtask
    // BCD to int; bad digit gives -1
    function automatic int bcd2int(input logic [31:0] b);
        int r;
        r = 0;
        for (int i = 7; i >= 0; i--) begin
            if (b[4*i +: 4] > 4'h9) begin
                return -1;
            end
            r = r * 10 + int'(b[4*i +: 4]);
        end
        return r;
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    // Reset values, refused accesses
    task automatic testReset;
        logic [31:0] v;
        logic e;
        rd(IDX_STATUS, v, e);
        chk(v, 32'h0000001F);
        rd(IDX_TA_PRE, v, e);
        chk(v, PRE_RST);
        rd(14'h0900, v, e);
        chk(32'(e), 32'h00000001);
        wr(W_UC, 32'h00000005, e);
        chk(32'(e), 32'h00000001);
        rd(W_UC, v, e);
        chk(v, 32'h00000000);
        $display("test reset done, mismatches %0d", mismatches);
    endtask
    // Timers: steps, freeze, resume, reset, done
    task automatic testTimers;
        atc_ctrl_t c;
        logic [31:0] v, a;
        logic e;
        int n;
        wr(IDX_TA_PRE, 32'h00000005, e);
        wr(IDX_TF_PRE, 32'h00000200, e);
        c = '0;
        c.taEn = 1'b1;
        c.tfEn = 1'b1;
        wr(IDX_CTRL, 32'(c), e);
        repeat (400) @(posedge clk);
        wr(IDX_CTRL, 32'h0, e);
        // Some 404 enabled cycles
        rd(W_TF_LO, v, e);
        n = bcd2int(v);
        chk(32'(n >= 99 && n <= 103), 32'h1);
        rd(W_TA_LO, a, e);
        n = bcd2int(a);
        chk(32'(n >= 9 && n <= 11), 32'h1);
        rd(W_TA_HI, v, e);
        chk(v, 32'h0);
        chk(32'(doneBits), 32'h0000001D);
        repeat (200) @(posedge clk);
        rd(W_TA_LO, v, e);
        chk(v, a);
        c = '0;
        c.taEn = 1'b1;
        wr(IDX_CTRL, 32'(c), e);
        repeat (100) @(posedge clk);
        wr(IDX_CTRL, 32'h0, e);
        rd(W_TA_LO, v, e);
        chk(32'(bcd2int(v) >= n + 1 && bcd2int(v) <= n + 4), 32'h1);
        // Reset wins over enable
        c = '0;
        c.taEn = 1'b1;
        c.tfEn = 1'b1;
        c.taRst = 1'b1;
        c.tfRst = 1'b1;
        wr(IDX_CTRL, 32'(c), e);
        repeat (100) @(posedge clk);
        rd(W_TA_LO, v, e);
        chk(v, 32'h0);
        rd(W_TF_LO, v, e);
        chk(v, 32'h0);
        wr(IDX_CTRL, 32'h0, e);
        repeat (4) @(posedge clk);
        chk(32'(doneBits), 32'h0000001C);
        $display("test timers done, mismatches %0d", mismatches);
    endtask
    // Up and stage counters to saturation
    task automatic testUpStage;
        atc_ctrl_t c, pu;
        logic [31:0] v;
        logic e;
        wr(IDX_UC_PRE, 32'h00000003, e);
        wr(IDX_SG_PRE, 32'h00000005, e);
        pu = '0;
        pu.ucIn = 1'b1;
        pu.sgIn = 1'b1;
        for (int p = 1; p <= 10000; p++) begin
            pulse('0, pu);
            if (p == 2 || p == 3) begin
                repeat (4) @(posedge clk);
                chk(32'(doneBits.uc), 32'(p == 3));
            end
            if (p == 10) begin
                rd(W_UC, v, e);
                chk(v, 32'h00000010);
                rd(W_SG, v, e);
                chk(v, 32'h00000010);
            end
        end
        rd(W_UC, v, e);
        chk(v, 32'h00009999);
        rd(W_SG, v, e);
        chk(v, 32'h00009999);
        chk(32'(doneBits.sg), 32'h1);
        // Pulse under reset is lost; stage ignores it
        c = '0;
        c.ucRst = 1'b1;
        pulse(c, pu);
        rd(W_UC, v, e);
        chk(v, 32'h0);
        chk(32'(doneBits.uc), 32'h0);
        rd(W_SG, v, e);
        chk(v, 32'h00009999);
        // Held input counts once
        wr(IDX_CTRL, 32'(pu), e);
        wr(IDX_CTRL, 32'(pu), e);
        wr(IDX_CTRL, 32'h0, e);
        rd(W_UC, v, e);
        chk(v, 32'h00000001);
        wr(IDX_CMD, 32'(1) << CMD_SG_CLR_BIT, e);
        rd(W_SG, v, e);
        chk(v, 32'h0);
        repeat (4) @(posedge clk);
        chk(32'(doneBits.sg), 32'h0);
        $display("test up and stage done, mismatches %0d", mismatches);
    endtask
    // Up/down: both ways, floor, reset
    task automatic testUpDown;
        atc_ctrl_t up, dn;
        logic [31:0] v;
        logic e;
        up = '0;
        up.udUp = 1'b1;
        dn = '0;
        dn.udDn = 1'b1;
        wr(IDX_UD_PRE, 32'h00000002, e);
        repeat (3) pulse('0, up);
        rd(W_UD_LO, v, e);
        chk(v, 32'h00000003);
        rd(W_UD_HI, v, e);
        chk(v, 32'h0);
        chk(32'(doneBits.ud), 32'h1);
        repeat (2) pulse('0, dn);
        repeat (4) @(posedge clk);
        chk(32'(doneBits.ud), 32'h0);
        repeat (2) pulse('0, dn);
        rd(W_UD_LO, v, e);
        chk(v, 32'h0);
        pulse('0, up);
        up.udRst = 1'b1;
        wr(IDX_CTRL, 32'(up & ~32'h40), e);
        rd(W_UD_LO, v, e);
        chk(v, 32'h0);
        wr(IDX_CTRL, 32'h0, e);
        // Byte lane 0 only
        atc_ladder_model_inst.xfer(1'b1, IDX_UD_PRE, 32'h12345678, 4'h1, v, e);
        rd(IDX_UD_PRE, v, e);
        chk(v, 32'h00000078);
        $display("test up down done, mismatches %0d", mismatches);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        rst_n = 1'b0;
        mismatches = 0;
        checked = 0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        testReset();
        testTimers();
        testUpStage();
        testUpDown();
        conclude();
    end
endmodule
`default_nettype wire
